// [tb.sv]
// Bench for the external-move steering block
`default_nettype none
module tb;
   import xcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pin = 0;
   logic mv_req = 0, mv_write = 0, mv_idx = 0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, mv_wdata = 8'h00, reg_rdata, mv_rdata;
   logic [15:0] mv_ptr = 16'h0000;
   logic [7:0] can_addr, p0_o, p0_i, rv, p2_o, can_wd;
   logic [7:0] can_last = 8'h00, n_can = 8'h00;
   logic mv_done, rd_n, wr_n, oe_n, p2_bus, can_sel, can_wr;
   logic [2:0] f;
   int miscompares = 0, n_compared = 0, cyc = 0;
   always #12.5 core_clk = ~core_clk;
   // Window reads answer a pattern of their own address
   wire [7:0] can_rdata = can_addr ^ 8'h3C;
   // Window writes land in one byte; selects are counted
   always @(posedge core_clk) begin
      if (can_wr) can_last <= can_wd;
      if (can_sel) n_can <= n_can + 8'h01;
   end
   xcs_steer uut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mv_req(mv_req), .mv_write(mv_write),
      .mv_idx(mv_idx), .mv_ptr(mv_ptr), .mv_wdata(mv_wdata),
      .mv_rdata(mv_rdata), .mv_done(mv_done), .external_access_pin(pin),
      .can_sel(can_sel), .can_wr(can_wr), .can_addr(can_addr),
      .can_wdata(can_wd),
      .can_rdata(can_rdata), .port_zero_o(p0_o), .port_zero_oe_n(oe_n),
      .port_zero_i(p0_i), .port_two_o(p2_o), .port_two_bus(p2_bus),
      .rd_n(rd_n), .wr_n(wr_n));
   xcs_ext_mem mem (.core_clk(core_clk), .wr_n(wr_n), .port_zero_o(p0_o),
      .port_zero_i(p0_i));
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rw(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : rw
   task automatic rr(input logic [1:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rr
   // One move; done cycle flags land in f, read data in rv
   task automatic mv(input logic w, input logic ix, input logic [15:0] p,
                     input logic [7:0] d, input logic [2:0] fe);
      @(posedge core_clk);
      mv_req <= 1'b1; mv_write <= w; mv_idx <= ix; mv_ptr <= p;
      mv_wdata <= d;
      @(posedge core_clk);
      mv_req <= 1'b0;
      #1 f = {mv_done, rd_n, wr_n};
      rv = mv_rdata;
      chk({5'h00, f}, {5'h00, fe});
   endtask : mv
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      rr(OFS_SYSCTL, SYSCTL_RST);
      rr(OFS_PAGE, PAGE_RST);
      rr(2'h3, 8'h00);
      mv(1, 0, 16'hF800, 8'h11, 3'b110);
      rr(OFS_STATUS, 8'h02);
      $display("reset and disabled moves done");
      rw(OFS_SYSCTL, 8'hFC);
      rr(OFS_SYSCTL, 8'hFC);
      rw(OFS_SYSCTL, 8'h05);
      rr(OFS_SYSCTL, 8'h04);
      $display("protected disable done");
      mv(1, 0, 16'hF800, 8'hA7, 3'b111);
      chk({7'h00, oe_n}, 8'h00);
      mv(0, 0, 16'hF800, 8'h00, 3'b111);
      chk(rv, 8'hA7);
      rr(OFS_STATUS, 8'h01);
      mv(0, 0, 16'hF7FF, 8'h00, 3'b111);
      chk(rv, 8'hC3);
      mv(1, 0, 16'hF710, 8'h5E, 3'b111);
      chk(can_last, 8'h5E);
      mv(1, 0, 16'hF6FF, 8'h33, 3'b110);
      mv(0, 0, 16'hF6FF, 8'h00, 3'b101);
      chk(rv, 8'h69);
      rw(OFS_PAGE, 8'hF8);
      mv(0, 1, 16'h0000, 8'h00, 3'b111);
      chk(rv, 8'hA7);
      rw(OFS_PAGE, 8'hF6);
      mv(0, 1, 16'h0000, 8'h00, 3'b101);
      @(posedge core_clk);
      pin <= 1'b1;
      mv(1, 0, 16'hF900, 8'h00, 3'b111);
      chk({7'h00, oe_n}, 8'h01);
      $display("hidden steering done");
      rw(OFS_SYSCTL, 8'h02);
      mv(0, 0, 16'hF800, 8'h00, 3'b101);
      chk(rv, 8'hA7);
      mv(1, 0, 16'hF801, 8'h44, 3'b110);
      chk(p0_o, 8'h44);
      chk(p2_o, 8'hF8);
      chk({7'h00, p2_bus}, 8'h01);
      mv(0, 1, 16'h0000, 8'h00, 3'b101);
      chk({7'h00, p2_bus}, 8'h00);
      $display("visible steering done");
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rr(OFS_SYSCTL, SYSCTL_RST);
      rw(OFS_SYSCTL, 8'h03);
      rr(OFS_SYSCTL, 8'h03);
      mv(0, 0, 16'hF800, 8'h00, 3'b101);
      chk(rv, 8'h1E);
      rr(OFS_STATUS, 8'h02);
      chk(n_can, 8'h02);
      $display("reset and disabled visibility done");
      test_done();
   end
endmodule : tb
`default_nettype wire

// [xcs_ext_mem.sv]
// External data memory model on the multiplexed bus
`default_nettype none
module xcs_ext_mem (
   // Clock
   input  wire logic       core_clk,
   // Bus strobes and data
   input  wire logic       wr_n,
   input  wire logic [7:0] port_zero_o,
   output logic      [7:0] port_zero_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_ff = 8'h00;
   // Keep last written byte; bench expects it scrambled back
   always @(posedge core_clk) begin
      if (!wr_n) last_ff <= port_zero_o;
   end
   assign port_zero_i = last_ff ^ 8'h5A;
endmodule : xcs_ext_mem
`default_nettype wire

// [xcs_pkg.sv]
// Package of constants for the external-move access steering block
`default_nettype none
package xcs_pkg;
   // Register map on the plain register port
   localparam logic [1:0] OFS_SYSCTL = 2'h0;
   localparam logic [1:0] OFS_PAGE   = 2'h1;
   localparam logic [1:0] OFS_STATUS = 2'h2;
   // System control fields
   localparam int BIT_GDIS = 0;
   localparam int BIT_VIS  = 1;
   localparam logic [7:0] SYSCTL_RST = 8'h01;
   localparam logic [7:0] SYSCTL_WMASK = 8'hFE;
   localparam logic [7:0] PAGE_RST = 8'h00;
   // Address map of the on-chip range
   localparam logic [15:0] INT_BASE  = 16'hF700;
   localparam logic [7:0]  INT_PAGE  = 8'hF7;
   localparam logic [15:0] CAN_BASE  = 16'hF700;
   localparam logic [15:0] RAM_BASE  = 16'hF800;
   localparam int          RAM_BYTES = 2048;
   localparam int          CAN_BYTES = 256;
   typedef enum logic [1:0] {XCS_IDLE, XCS_DONE} xcs_state_e;
endpackage : xcs_pkg
`default_nettype wire

// [xcs_steer.sv]
// External-move access steering to on-chip RAM, CAN window or external bus
// Notes on behaviour
// - Global disable low sends on-chip range moves to internal RAM or CAN.
// - Global disable high sends every move external; it resets to one.
// - Once cleared, software cannot set global disable again; only reset.
// - Visibility low keeps read and write strobes idle on internal access.
// - Visibility high drives port zero and strobes during internal accesses, and port two on pointer moves.
// - Visibility has no effect outside internal range or when disabled.
// - Pointer moves at F700 through FFFF hex are internal accesses.
// - Index moves take upper address bits from the page register.
// - Port behaviour follows disable, visibility and access pin together.
// - Two kilobytes of internal RAM at top of data space.
// - A 256-byte CAN window shares the same move address range.
// - Up to 64 kilobytes external data memory when not steered inside.
// - Below range or disable set goes external; pin high hides ports on hidden internal access.
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
module xcs_steer
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Register port
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // CPU external move request
   input  wire logic        mv_req,
   input  wire logic        mv_write,
   input  wire logic        mv_idx,
   input  wire logic [15:0] mv_ptr,
   input  wire logic [7:0]  mv_wdata,
   output logic      [7:0]  mv_rdata,
   output logic             mv_done,
   // Access pin level
   input  wire logic        external_access_pin,
   // CAN window
   output logic             can_sel,
   output logic             can_wr,
   output logic      [7:0]  can_addr,
   output logic      [7:0]  can_wdata,
   input  wire logic [7:0]  can_rdata,
   // External bus
   output logic      [7:0]  port_zero_o,
   output logic             port_zero_oe_n,
   input  wire logic [7:0]  port_zero_i,
   output logic      [7:0]  port_two_o,
   output logic             port_two_bus,
   output logic             rd_n,
   output logic             wr_n
);
   import xcs_pkg::*;

   typedef struct packed {
      logic [7:0]  sysctl;
      logic [7:0]  page;
      logic [7:0]  rdata;
      logic [7:0]  mvdata;
      logic        done;
      logic        last_int;
      logic        last_ext;
      logic [7:0]  p0;
      logic        p0_oe_n;
      logic [7:0]  p2;
      logic        p2_bus;
      logic        rd_n;
      logic        wr_n;
      xcs_state_e  st;
   } xcs_s;

   xcs_s st_ff;
   xcs_s nxt_st;

   logic [7:0] ram_ff [RAM_BYTES];

   logic [15:0] eff_addr;
   logic        in_range;
   logic        gdis;
   logic        vis;
   logic        go_int;
   logic        is_can;
   logic [10:0] ram_idx;
   logic        strobe_on;
   logic        p0_bus;
   logic        p2_on_bus;

   function automatic logic in_int_range(input logic [15:0] a);
      return a >= INT_BASE;
   endfunction : in_int_range

   assign gdis     = st_ff.sysctl[BIT_GDIS];
   assign vis      = st_ff.sysctl[BIT_VIS];
   // Index moves borrow the page for A8-A15
   assign eff_addr = mv_idx ? {st_ff.page, mv_ptr[7:0]} : mv_ptr;
   assign in_range = in_int_range(eff_addr);
   assign go_int   = in_range && !gdis;
   assign is_can   = eff_addr < RAM_BASE;
   assign ram_idx  = eff_addr[10:0];

   // Strobes: external always; internal only when visible
   assign strobe_on = !go_int || vis;
   // Pin high with internal hidden access keeps ports as plain I/O
   assign p0_bus    = !(go_int && !vis && external_access_pin);
   // Index moves never put the page on port two
   assign p2_on_bus = p0_bus && !mv_idx;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.rd_n = 1'b1;
      nxt_st.wr_n = 1'b1;
      nxt_st.p0_oe_n = 1'b1;
      nxt_st.p2_bus  = 1'b0;
      nxt_st.rdata   = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            OFS_SYSCTL: begin
               nxt_st.sysctl = (reg_wdata & SYSCTL_WMASK) |
                  {7'h00, reg_wdata[BIT_GDIS] & gdis};
            end
            OFS_PAGE: nxt_st.page = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_SYSCTL: nxt_st.rdata = st_ff.sysctl;
            OFS_PAGE:   nxt_st.rdata = st_ff.page;
            OFS_STATUS: nxt_st.rdata = {6'h00, st_ff.last_ext,
                                        st_ff.last_int};
            default:    nxt_st.rdata = 8'h00;
         endcase
      end
      case (st_ff.st)
         XCS_IDLE: begin
            if (mv_req) begin
               nxt_st.st       = XCS_DONE;
               nxt_st.done     = 1'b1;
               nxt_st.last_int = go_int;
               nxt_st.last_ext = !go_int;
               nxt_st.rd_n     = !(strobe_on && !mv_write);
               nxt_st.wr_n     = !(strobe_on && mv_write);
               nxt_st.p0_oe_n  = !p0_bus;
               nxt_st.p2_bus   = p2_on_bus;
               nxt_st.p0       = mv_write ? mv_wdata : eff_addr[7:0];
               nxt_st.p2       = eff_addr[15:8];
               if (go_int) begin
                  nxt_st.mvdata = is_can ? can_rdata : ram_ff[ram_idx];
               end else begin
                  nxt_st.mvdata = port_zero_i;
               end
            end
         end
         XCS_DONE: nxt_st.st = XCS_IDLE;
         default:  nxt_st.st = XCS_IDLE;
      endcase
      if (srst) begin
         nxt_st          = '0;
         nxt_st.sysctl   = SYSCTL_RST;
         nxt_st.page     = PAGE_RST;
         nxt_st.rd_n     = 1'b1;
         nxt_st.wr_n     = 1'b1;
         nxt_st.p0_oe_n  = 1'b1;
         nxt_st.st       = XCS_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   // Storage has no reset; contents are undefined until written
   always_ff @(posedge core_clk) begin
      if (!srst && st_ff.st == XCS_IDLE && mv_req && mv_write && go_int &&
          !is_can) begin
         ram_ff[ram_idx] <= mv_wdata;
      end
   end

   // CAN window is combinational so its read data lands in the same cycle
   assign can_sel   = st_ff.st == XCS_IDLE && mv_req && go_int && is_can;
   assign can_wr    = can_sel && mv_write;
   assign can_addr  = eff_addr[7:0];
   assign can_wdata = mv_wdata;

   assign reg_rdata      = st_ff.rdata;
   assign mv_rdata       = st_ff.mvdata;
   assign mv_done        = st_ff.done;
   assign port_zero_o    = st_ff.p0;
   assign port_zero_oe_n = st_ff.p0_oe_n;
   assign port_two_o     = st_ff.p2;
   assign port_two_bus   = st_ff.p2_bus;
   assign rd_n           = st_ff.rd_n;
   assign wr_n           = st_ff.wr_n;

   property p_gdis_sticky;
      @(posedge core_clk) disable iff (srst)
      !gdis |=> !gdis;
   endproperty
   a_gdis_sticky: assert property (p_gdis_sticky)
      else $error("global disable set again by software");

   property p_reset_gdis;
      @(posedge core_clk) srst |=> gdis;
   endproperty
   a_reset_gdis: assert property (p_reset_gdis)
      else $error("global disable not set by reset");

   property p_disabled_ext;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && gdis) |=> st_ff.last_ext;
   endproperty
   a_disabled_ext: assert property (p_disabled_ext)
      else $error("access steered inside while disabled");

   property p_int_route;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && !gdis && !mv_idx &&
       mv_ptr >= INT_BASE) |=> st_ff.last_int;
   endproperty
   a_int_route: assert property (p_int_route)
      else $error("on-chip range access went external");

   property p_low_ext;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && !mv_idx && mv_ptr < INT_BASE)
      |=> (st_ff.last_ext && (!rd_n || !wr_n));
   endproperty
   a_low_ext: assert property (p_low_ext)
      else $error("low address not external with strobe");

   property p_hidden;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && go_int && !vis) |=> (rd_n && wr_n);
   endproperty
   a_hidden: assert property (p_hidden)
      else $error("strobe active on hidden internal access");

   property p_visible;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && go_int && vis) |=>
         (!port_zero_oe_n && (rd_n != wr_n));
   endproperty
   a_visible: assert property (p_visible)
      else $error("visible internal access not shown on bus");

   property p_pin_io;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && go_int && !vis &&
       external_access_pin) |=> (port_zero_oe_n && !port_two_bus);
   endproperty
   a_pin_io: assert property (p_pin_io)
      else $error("ports driven on hidden access with pin high");

   property p_done;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req) |=> mv_done ##1 !mv_done;
   endproperty
   a_done: assert property (p_done)
      else $error("move completion not a single pulse");

   property p_ext_bus;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && !go_int) |=>
         (!port_zero_oe_n && (rd_n != wr_n));
   endproperty
   a_ext_bus: assert property (p_ext_bus)
      else $error("external move without bus and strobe");

   // Index moves leave port two as plain I/O in every mode
   property p_idx_p2;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && mv_idx) |=> !port_two_bus;
   endproperty
   a_idx_p2: assert property (p_idx_p2)
      else $error("port two on bus during index move");

   property p_ptr_p2;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && !mv_idx && !go_int) |=>
         port_two_bus;
   endproperty
   a_ptr_p2: assert property (p_ptr_p2)
      else $error("port two off bus on external pointer move");

   property p_pin_low;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && go_int && !vis &&
       !external_access_pin) |=> (!port_zero_oe_n && rd_n && wr_n);
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("hidden access with pin low not on bus quietly");

   property p_vis_nop;
      @(posedge core_clk) disable iff (srst)
      (st_ff.st == XCS_IDLE && mv_req && gdis && vis) |=>
         (st_ff.last_ext && (rd_n != wr_n));
   endproperty
   a_vis_nop: assert property (p_vis_nop)
      else $error("visibility changed a disabled access");

   property p_gdis_clear;
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == OFS_SYSCTL && !reg_wdata[BIT_GDIS]) |=> !gdis;
   endproperty
   a_gdis_clear: assert property (p_gdis_clear)
      else $error("global disable not cleared by software");

   property p_ctl_bits;
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == OFS_SYSCTL) |=>
         (st_ff.sysctl[7:1] == $past(reg_wdata[7:1]));
   endproperty
   a_ctl_bits: assert property (p_ctl_bits)
      else $error("plain control bits not written");

   property p_page_wr;
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == OFS_PAGE) |=> (st_ff.page == $past(reg_wdata));
   endproperty
   a_page_wr: assert property (p_page_wr)
      else $error("page register not written");
endmodule : xcs_steer
`default_nettype wire
